//--- psc_top.v
// Purpose: MAC-side control of a 10/100 transceiver.
// Assumes: Line coding outside hands symbols in on sys_clk.
// Notes: MII clocks divide sys_clk; pins pass two flip-flops.
`timescale 1ns/10ps
`include "psc_map.vh"

module psc_fifo #(
    parameter W = 4,
    parameter D = 8,
    parameter AW = 3
) (
    input wire sys_clk,
    input wire nrst,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_q[AW-1:0]];

    always @(posedge sys_clk)
    begin
        if (in_valid && !full)
        begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (in_valid && !full)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (out_ready && !empty)
            begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

module psc_top (
    input wire sys_clk,
    input wire nrst,
    input wire interface_select_strap,
    input wire negotiation_enable_strap,
    input wire speed_strap,
    input wire duplex_strap,
    input wire isolate_strap,
    input wire repeater_strap,
    input wire link_down_power_save,
    input wire [4:0] phy_addr_strap,
    input wire mdc,
    input wire mdio_in,
    output wire mdio_out,
    output wire mdio_oe_n,
    output wire mii_tx_clk,
    input wire mii_tx_en,
    input wire [3:0] mii_txd,
    input wire mii_tx_er,
    output wire mii_rx_clk,
    output wire mii_rx_dv,
    output wire [3:0] mii_rxd,
    output wire mii_crs,
    output wire mii_oe_n,
    input wire line_link_good,
    input wire line_energy,
    input wire rx_sym_valid,
    input wire [4:0] rx_sym,
    input wire rx10_preamble_ok,
    input wire rx10_idle_ok,
    input wire rx10_nib_valid,
    input wire [3:0] rx10_nib,
    output wire rx_nib_ready,
    input wire an_flp_seen,
    input wire an_nlp_seen,
    input wire an_idle100_seen,
    input wire partner_valid,
    input wire [15:0] partner_ability,
    input wire [7:0] cable_length_result,
    output wire line_tx_valid,
    output wire [3:0] line_tx_nibble,
    output wire speed_100,
    output wire full_duplex,
    output wire link_up,
    output wire link_pulse_en,
    output wire send_flp,
    output wire repeater_mode,
    output wire sni_mode,
    output wire heartbeat_enable,
    output wire jabber_enable,
    output wire link_disable_n,
    output wire [7:0] pll_select
);
    localparam M_IDLE = 3'h0;
    localparam M_START = 3'h1;
    localparam M_HDR = 3'h2;
    localparam M_TA = 3'h3;
    localparam M_DATA = 3'h4;

    // 5B to 4B; bit 4 flags a data code.
    function [4:0] psc_dec;
        input [4:0] sym;
        begin
            case (sym)
                5'h1e: psc_dec = 5'h10;
                5'h09: psc_dec = 5'h11;
                5'h14: psc_dec = 5'h12;
                5'h15: psc_dec = 5'h13;
                5'h0a: psc_dec = 5'h14;
                5'h0b: psc_dec = 5'h15;
                5'h0e: psc_dec = 5'h16;
                5'h0f: psc_dec = 5'h17;
                5'h12: psc_dec = 5'h18;
                5'h13: psc_dec = 5'h19;
                5'h16: psc_dec = 5'h1a;
                5'h17: psc_dec = 5'h1b;
                5'h1a: psc_dec = 5'h1c;
                5'h1b: psc_dec = 5'h1d;
                5'h1c: psc_dec = 5'h1e;
                5'h1d: psc_dec = 5'h1f;
                default: psc_dec = 5'h00;
            endcase
        end
    endfunction

    // Pin synchronisers; stage one feeds only stage two.
    reg [10:0] pin_s1;
    reg [10:0] pin_s2;
    reg [4:0] tx_s1;
    reg [4:0] tx_s2;
    reg mdc_s3;
    always @(posedge sys_clk)
    begin
        pin_s1 <= {mdc, mdio_in, phy_addr_strap, interface_select_strap,
                   negotiation_enable_strap, speed_strap, duplex_strap};
        pin_s2 <= pin_s1;
        tx_s1 <= {mii_tx_en, mii_txd};
        tx_s2 <= tx_s1;
        mdc_s3 <= pin_s2[10];
    end
    reg [2:0] str_s1;
    reg [2:0] str_s2;
    always @(posedge sys_clk)
    begin
        str_s1 <= {isolate_strap, repeater_strap, link_down_power_save};
        str_s2 <= str_s1;
    end

    wire mdc_rise = pin_s2[10] && !mdc_s3;
    wire mdio_bit = pin_s2[9];
    wire tx_en_s = tx_s2[4];

    // Straps and configuration registers.
    reg strap_done_q;
    reg iface_q;
    reg ane_q;
    reg spd_q;
    reg dux_q;
    reg iso_q;
    reg rpt_q;
    reg link_down_power_save_q;
    reg [4:0] phyad_q;
    reg [15:0] adv_q;
    reg [15:0] lpa_q;
    reg [15:0] cfg_q;
    reg [15:0] tuna_q;
    reg [15:0] tunb_q;
    reg [15:0] drva_q;
    reg [15:0] drvb_q;
    reg [7:0] pll_q;

    // MDIO slave state.
    reg [2:0] mst_q;
    reg [4:0] mcnt_q;
    reg ones_q;
    reg [11:0] hdr_q;
    reg [15:0] sh_q;
    reg mout_q;
    reg moe_n_q;
    wire wr_commit = (mst_q == M_DATA) && mdc_rise && !hdr_q[11] &&
                     (mcnt_q == `PSC_DATA_BITS - 5'h01);
    wire [15:0] wr_data = {sh_q[14:0], mdio_bit};
    wire [4:0] reg_addr = hdr_q[4:0];
    reg [15:0] rd_mux;

    always @*
    begin
        case (reg_addr)
            `PSC_REG_ADV: rd_mux = adv_q;
            `PSC_REG_LPA: rd_mux = lpa_q;
            `PSC_REG_CFG10: rd_mux = cfg_q;
            `PSC_REG_TUNA: rd_mux = tuna_q;
            `PSC_REG_TUNB: rd_mux = tunb_q;
            `PSC_REG_CABLE: rd_mux = {cable_length_result, pll_q};
            `PSC_REG_DRVA: rd_mux = drva_q;
            `PSC_REG_DRVB: rd_mux = drvb_q;
            default: rd_mux = 16'h0000;
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            strap_done_q <= 1'b0;
            iface_q <= 1'b1;
            ane_q <= 1'b1;
            spd_q <= 1'b1;
            dux_q <= 1'b1;
            iso_q <= 1'b0;
            rpt_q <= 1'b0;
            link_down_power_save_q <= 1'b0;
            phyad_q <= 5'h00;
            adv_q <= `PSC_ADV_SEL;
            lpa_q <= 16'h0000;
            cfg_q <= `PSC_CFG_RST;
            tuna_q <= `PSC_TUN_RST;
            tunb_q <= `PSC_TUN_RST;
            drva_q <= `PSC_TUN_RST;
            drvb_q <= `PSC_TUN_RST;
            pll_q <= `PSC_PLL_RST;
        end
        else
        begin
            if (!strap_done_q)
            begin
                strap_done_q <= 1'b1;
                phyad_q <= pin_s2[8:4];
                iface_q <= pin_s2[3];
                ane_q <= pin_s2[2];
                spd_q <= pin_s2[1];
                dux_q <= pin_s2[0];
                iso_q <= str_s2[2];
                rpt_q <= str_s2[1];
                link_down_power_save_q <= str_s2[0];
                adv_q[`PSC_ADV_10HD] <= 1'b1;
                adv_q[`PSC_ADV_10FD] <= pin_s2[0];
                adv_q[`PSC_ADV_100HD] <= pin_s2[1];
                adv_q[`PSC_ADV_100FD] <= pin_s2[1] && pin_s2[0];
            end
            if (partner_valid)
            begin
                lpa_q <= partner_ability;
            end
            if (wr_commit)
            begin
                case (reg_addr)
                    `PSC_REG_ADV: adv_q <= wr_data;
                    `PSC_REG_CFG10: cfg_q <= wr_data & `PSC_CFG_WMASK;
                    `PSC_REG_TUNA: tuna_q <= wr_data;
                    `PSC_REG_TUNB: tunb_q <= wr_data;
                    `PSC_REG_CABLE: pll_q <= wr_data[7:0];
                    `PSC_REG_DRVA: drva_q <= wr_data;
                    `PSC_REG_DRVB: drvb_q <= wr_data;
                    default: ;
                endcase
            end
        end
    end

    // Management frame decoder.
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            mst_q <= M_IDLE;
            mcnt_q <= 5'h00;
            ones_q <= 1'b0;
            hdr_q <= 12'h000;
            sh_q <= 16'h0000;
            mout_q <= 1'b1;
            moe_n_q <= 1'b1;
        end
        else if (iso_q)
        begin
            mst_q <= M_IDLE;
            moe_n_q <= 1'b1;
        end
        else if (mdc_rise)
        begin
            case (mst_q)
                M_IDLE:
                begin
                    ones_q <= mdio_bit;
                    if (ones_q && !mdio_bit)
                    begin
                        mst_q <= M_START;
                    end
                end
                M_START:
                begin
                    mcnt_q <= 5'h00;
                    mst_q <= mdio_bit ? M_HDR : M_IDLE;
                end
                M_HDR:
                begin
                    hdr_q <= {hdr_q[10:0], mdio_bit};
                    mcnt_q <= mcnt_q + 5'h01;
                    if (mcnt_q == `PSC_HDR_BITS - 5'h01)
                    begin
                        mcnt_q <= 5'h00;
                        if ((hdr_q[8:4] == phyad_q) &&
                            ((hdr_q[10:9] == `PSC_OP_RD) || (hdr_q[10:9] == `PSC_OP_WR)))
                        begin
                            mst_q <= M_TA;
                        end
                        else
                        begin
                            mst_q <= M_IDLE;
                            ones_q <= 1'b0;
                        end
                    end
                end
                M_TA:
                begin
                    mcnt_q <= mcnt_q + 5'h01;
                    if (mcnt_q == 5'h00)
                    begin
                        sh_q <= rd_mux;
                        if (hdr_q[11])
                        begin
                            mout_q <= 1'b0;
                            moe_n_q <= 1'b0;
                        end
                    end
                    else if (mcnt_q == `PSC_TA_BITS - 5'h01)
                    begin
                        mcnt_q <= 5'h00;
                        mst_q <= M_DATA;
                        if (hdr_q[11])
                        begin
                            mout_q <= sh_q[15];
                            sh_q <= {sh_q[14:0], 1'b0};
                        end
                    end
                end
                M_DATA:
                begin
                    mcnt_q <= mcnt_q + 5'h01;
                    if (hdr_q[11])
                    begin
                        mout_q <= sh_q[15];
                        sh_q <= {sh_q[14:0], 1'b0};
                    end
                    else
                    begin
                        sh_q <= wr_data;
                    end
                    if (mcnt_q == `PSC_DATA_BITS - 5'h01)
                    begin
                        mst_q <= M_IDLE;
                        ones_q <= 1'b0;
                        moe_n_q <= 1'b1;
                        mout_q <= 1'b1;
                    end
                end
                default:
                begin
                    mst_q <= M_IDLE;
                end
            endcase
        end
    end

    // Speed and duplex resolution.
    reg speed_q;
    reg duplex_q;
    wire [3:0] common = adv_q[`PSC_ADV_100FD:`PSC_ADV_10HD] &
                        partner_ability[`PSC_ADV_100FD:`PSC_ADV_10HD];
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            speed_q <= 1'b0;
            duplex_q <= 1'b0;
        end
        else if (!iface_q)
        begin
            speed_q <= 1'b0;
            duplex_q <= dux_q;
        end
        else if (!ane_q)
        begin
            speed_q <= spd_q;
            duplex_q <= dux_q;
        end
        else if (partner_valid)
        begin
            speed_q <= common[3] || common[2];
            duplex_q <= common[3] || (!common[2] && common[1]);
        end
        else if (an_nlp_seen)
        begin
            speed_q <= 1'b0;
            duplex_q <= 1'b0;
        end
        else if (an_idle100_seen)
        begin
            speed_q <= 1'b1;
            duplex_q <= 1'b0;
        end
    end

    wire link_q_w = line_link_good || (!speed_q && !cfg_q[`PSC_CFG_LDN]);

    // One divider makes both MII clocks.
    reg [2:0] div_q;
    reg mclk_q;
    wire [2:0] half = speed_q ? `PSC_HALF_100 : `PSC_HALF_10;
    wire div_end = (div_q >= half);
    wire mclk_rise = div_end && !mclk_q;
    wire mclk_fall = div_end && mclk_q;
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            div_q <= 3'h0;
            mclk_q <= 1'b0;
        end
        else
        begin
            div_q <= div_end ? 3'h0 : div_q + 3'h1;
            if (div_end)
            begin
                mclk_q <= !mclk_q;
            end
        end
    end

    wire mii_on = iface_q && !iso_q;

    // Transmit: the error input is never read.
    reg txv_q;
    reg [3:0] txn_q;
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            txv_q <= 1'b0;
            txn_q <= 4'h0;
        end
        else
        begin
            txv_q <= mclk_rise && tx_en_s && mii_on;
            if (mclk_rise && tx_en_s)
            begin
                txn_q <= tx_s2[3:0];
            end
        end
    end

    // Receive framing.
    reg crs100_q;
    reg dv100_q;
    reg prev_j_q;
    reg prev_t_q;
    reg crs10_q;
    wire [4:0] dec = psc_dec(rx_sym);
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            crs100_q <= 1'b0;
            dv100_q <= 1'b0;
            prev_j_q <= 1'b0;
            prev_t_q <= 1'b0;
            crs10_q <= 1'b0;
        end
        else
        begin
            if (rx_sym_valid)
            begin
                prev_j_q <= (rx_sym == `PSC_SYM_J);
                prev_t_q <= (rx_sym == `PSC_SYM_T);
                if (rx_sym == `PSC_SYM_IDLE)
                begin
                    crs100_q <= 1'b0;
                    dv100_q <= 1'b0;
                end
                else
                begin
                    crs100_q <= 1'b1;
                    if (prev_j_q && (rx_sym == `PSC_SYM_K))
                    begin
                        dv100_q <= 1'b1;
                    end
                    else if (prev_t_q && (rx_sym == `PSC_SYM_R))
                    begin
                        dv100_q <= 1'b0;
                    end
                end
            end
            if (rx10_idle_ok)
            begin
                crs10_q <= 1'b0;
            end
            else if (rx10_preamble_ok)
            begin
                crs10_q <= 1'b1;
            end
        end
    end

    wire push100 = speed_q && rx_sym_valid && dv100_q && dec[4];
    wire push10 = !speed_q && crs10_q && rx10_nib_valid;
    wire [3:0] fifo_out;
    wire fifo_valid;
    psc_fifo #(
        .W(`PSC_FIFO_W),
        .D(`PSC_FIFO_D),
        .AW(`PSC_FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(push100 || push10),
        .in_ready(rx_nib_ready),
        .in_data(speed_q ? dec[3:0] : rx10_nib),
        .out_valid(fifo_valid),
        .out_ready(mclk_fall),
        .out_data(fifo_out)
    );

    // RXD and valid change at the clock's fall; carrier updates every cycle.
    reg [3:0] rxd_q;
    reg rxdv_q;
    reg crs_q;
    wire rx_crs = speed_q ? crs100_q : crs10_q;
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rxd_q <= 4'h0;
            rxdv_q <= 1'b0;
            crs_q <= 1'b0;
        end
        else
        begin
            crs_q <= mii_on && (rx_crs || (!rpt_q && tx_en_s));
            if (mclk_fall)
            begin
                rxdv_q <= mii_on && (speed_q ? dv100_q && fifo_valid : crs10_q);
                rxd_q <= (mii_on && fifo_valid) ? fifo_out : 4'h0;
            end
        end
    end

    assign mdio_out = mout_q;
    assign mdio_oe_n = moe_n_q;
    assign mii_tx_clk = mclk_q;
    assign mii_rx_clk = mclk_q;
    assign mii_rx_dv = rxdv_q;
    assign mii_rxd = rxd_q;
    assign mii_crs = crs_q;
    assign mii_oe_n = !mii_on;
    assign line_tx_valid = txv_q;
    assign line_tx_nibble = txn_q;
    assign speed_100 = speed_q;
    assign full_duplex = duplex_q;
    assign link_up = link_q_w;
    assign link_pulse_en = !link_down_power_save_q || link_q_w || line_energy;
    assign send_flp = ane_q && iface_q;
    assign repeater_mode = rpt_q;
    assign sni_mode = !iface_q;
    assign heartbeat_enable = cfg_q[`PSC_CFG_HB];
    assign jabber_enable = cfg_q[`PSC_CFG_JB];
    assign link_disable_n = cfg_q[`PSC_CFG_LDN];
    assign pll_select = pll_q;
endmodule

//--- psc_map.vh
// Purpose: Register map, fields, symbols and timing.
// Assumes: 16-bit registers, 5-bit register numbers.
// Notes: Included by psc_top.v only.
// Function
// - Config bit 5 low holds the 10M link good.
// - Config bits 1, 0: heartbeat, jabber enables, reset 1.
// - Reg 0x16: cable result high, PLL select low.
// - Interface strap high selects MII.
// - MII clock fast at 100M, slow at 10M.
// - TX nibbles sampled on MII clock while enabled.
// - RX nibbles go out on RXD with valid.
// - 100M carrier on non-idle, off on idle.
// - 10M carrier on preamble, off on idle.
// - 100M valid on J K, off on T R or idle.
// - 10M valid equals carrier.
// - TX error input ignored.
// - Negotiation picks the best common mode.
// - Pulses give 10M half; 100M idle gives 100M half.
// - Speed and duplex straps trim abilities.
// - Negotiation strap low forces mode.
// - Pause at bit 10 both ways.
// - Isolate strap cuts MII and management.
// - Repeater strap selects repeater mode.
// - Power-save strap enables link-down saving.
// - Interface strap low: serial, 10M only.
// - Repeater: carrier on receive only.
// - Saving stops pulses until link or energy.
`ifndef PSC_MAP_VH
`define PSC_MAP_VH
`define PSC_REG_ADV 5'h04
`define PSC_REG_LPA 5'h05
`define PSC_REG_CFG10 5'h13
`define PSC_REG_TUNA 5'h14
`define PSC_REG_TUNB 5'h15
`define PSC_REG_CABLE 5'h16
`define PSC_REG_DRVA 5'h17
`define PSC_REG_DRVB 5'h18
`define PSC_CFG_LDN 5
`define PSC_CFG_HB 1
`define PSC_CFG_JB 0
`define PSC_CFG_RST 16'h0023
`define PSC_CFG_WMASK 16'h0023
`define PSC_ADV_PAUSE 10
`define PSC_ADV_100FD 8
`define PSC_ADV_100HD 7
`define PSC_ADV_10FD 6
`define PSC_ADV_10HD 5
`define PSC_ADV_SEL 16'h0001
`define PSC_TUN_RST 16'h0000
`define PSC_PLL_RST 8'h00
`define PSC_SYM_IDLE 5'h1f
`define PSC_SYM_J 5'h18
`define PSC_SYM_K 5'h11
`define PSC_SYM_T 5'h0d
`define PSC_SYM_R 5'h07
`define PSC_HALF_100 3'h0
`define PSC_HALF_10 3'h1
`define PSC_OP_RD 2'h2
`define PSC_OP_WR 2'h1
`define PSC_HDR_BITS 5'h0c
`define PSC_TA_BITS 5'h02
`define PSC_DATA_BITS 5'h10
`define PSC_FIFO_W 4
`define PSC_FIFO_D 8
`define PSC_FIFO_AW 3
`endif

//--- psc_sva.sv
// Purpose: Port-level checks.
// Assumes: Straps steady out of reset.
// Notes: Strap checks wait three edges for the latch.
`timescale 1ns/10ps
module psc_sva (
    input wire sys_clk,
    input wire nrst,
    input wire interface_select_strap,
    input wire negotiation_enable_strap,
    input wire speed_strap,
    input wire duplex_strap,
    input wire isolate_strap,
    input wire repeater_strap,
    input wire link_down_power_save,
    input wire mdio_oe_n,
    input wire mii_oe_n,
    input wire rx_sym_valid,
    input wire [4:0] rx_sym,
    input wire mii_crs,
    input wire line_energy,
    input wire line_tx_valid,
    input wire speed_100,
    input wire full_duplex,
    input wire link_up,
    input wire link_pulse_en,
    input wire repeater_mode,
    input wire sni_mode,
    input wire link_disable_n
);
    reg [1:0] up_q;
    wire up;
    assign up = up_q == 2'h3;
    always @(posedge sys_clk)
        up_q <= !nrst ? 2'h0 : up_q + {1'h0, !up};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_iso_quiet: assert property (up && isolate_strap |-> mdio_oe_n && mii_oe_n)
        else $error("isolated drive");
    a_mii_select: assert property (up && interface_select_strap && !isolate_strap |-> !mii_oe_n)
        else $error("MII off");
    a_sni_slow: assert property (up && !interface_select_strap |-> sni_mode && !speed_100)
        else $error("serial fast");
    a_forced_mode: assert property (up && interface_select_strap && !negotiation_enable_strap
        |-> speed_100 == speed_strap && full_duplex == duplex_strap)
        else $error("forced mode");
    a_repeater_strap_follow: assert property (up |-> repeater_mode == repeater_strap)
        else $error("repeater mode");
    a_ps_quiet: assert property (up && link_down_power_save && !link_up && !$past(link_up)
        && !line_energy && !$past(line_energy) |-> !link_pulse_en)
        else $error("pulses in saving");
    a_crs_symbol: assert property (up && speed_100 && rx_sym_valid && rx_sym != 5'h1f |-> ##2 mii_crs)
        else $error("no carrier");
    a_link_forced: assert property (up && !link_disable_n && !speed_100 |-> link_up)
        else $error("link not good");
    c_tx: cover property (line_tx_valid);
    c_read: cover property (!mdio_oe_n);
    c_crs: cover property (mii_crs && speed_100);
endmodule
bind psc_top psc_sva chk (.*);

//--- psc_mac.sv
// Purpose: MAC model for the management port.
// Assumes: Data line pulled up when idle.
// Notes: Clock stands low between frames.
`timescale 1ns/10ps
module psc_mac (
    input wire sys_clk,
    output reg mdc = 1'h0,
    output reg mac_do = 1'h1,
    output reg mac_oe = 1'h0,
    input wire mdio_line
);
    task xfer(input [1:0] op, input [4:0] ad, input [4:0] ra, input [15:0] wd,
        output [15:0] rv);
        reg [63:0] f;
        integer k;
        begin
            f = {32'hffffffff, 2'h1, op, ad, ra, 2'h2, wd};
            rv = 16'h0000;
            for (k = 63; k >= 0; k = k - 1)
            begin
                @(posedge sys_clk);
                mdc <= 1'h0;
                mac_oe <= !(op == 2'h2 && k < 18);
                mac_do <= f[k];
                repeat (8) @(posedge sys_clk);
                if (k < 16)
                    rv[k] = mdio_line;
                mdc <= 1'h1;
                repeat (7) @(posedge sys_clk);
            end
            @(posedge sys_clk) {mdc, mac_oe} <= 2'h0;
            repeat (16) @(posedge sys_clk);
        end
    endtask
endmodule

//--- psc_top_bench.sv
// Purpose: Self-checking bench for psc_top.
// Assumes: Straps change only while reset is held.
// Notes: A small model predicts registers and nibbles.
`timescale 1ns/10ps
module psc_top_bench;
    reg sys_clk = 1'h0, nrst = 1'h0, interface_select_strap = 1'h0, speed_strap = 1'h0;
    reg negotiation_enable_strap = 1'h0, duplex_strap = 1'h0, isolate_strap = 1'h0;
    reg repeater_strap = 1'h0, link_down_power_save = 1'h0, mii_tx_en = 1'h0;
    reg mii_tx_er = 1'h0, line_link_good = 1'h0, line_energy = 1'h0, rx_sym_valid = 1'h0;
    reg rx10_preamble_ok = 1'h0, rx10_idle_ok = 1'h0, rx10_nib_valid = 1'h0, p = 1'h0;
    reg an_flp_seen = 1'h0, an_nlp_seen = 1'h0, an_idle100_seen = 1'h0, partner_valid = 1'h0;
    reg [4:0] phy_addr_strap = 5'h05, rx_sym = 5'h1f;
    reg [3:0] mii_txd = 4'h0, rx10_nib = 4'h0;
    reg [15:0] partner_ability = 16'h0000, r, v;
    reg [7:0] cable_length_result = 8'h00;
    wire mdc, mdio_in, mdio_out, mdio_oe_n, mii_tx_clk, mii_rx_clk, mii_rx_dv, mii_crs;
    wire mii_oe_n, rx_nib_ready, line_tx_valid, speed_100, full_duplex, link_up, send_flp;
    wire link_pulse_en, repeater_mode, sni_mode, heartbeat_enable, jabber_enable;
    wire link_disable_n, mac_do, mac_oe;
    wire [3:0] mii_rxd, line_tx_nibble;
    wire [7:0] pll_select;
    logic [15:0] mdl [0:31];
    logic [3:0] rq [$];
    logic [4:0] rl [0:6] = '{5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h1f};
    integer seed = 94710, error_cnt = 0, compares = 0, txn = 0, acc = 0, i;
    psc_top uut (.*);
    psc_mac mac (.sys_clk(sys_clk), .mdc(mdc), .mac_do(mac_do), .mac_oe(mac_oe),
        .mdio_line(mdio_in));
    assign mdio_in = !mdio_oe_n ? mdio_out : (mac_oe ? mac_do : 1'h1);
    task chk(input string n, input [15:0] s, input [15:0] e);
        begin
            compares = compares + 1;
            if (s !== e)
            begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %s expected %h seen %h", n, e, s);
            end
        end
    endtask
    task give_verdict;
        begin
            if (error_cnt == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task boot(input [6:0] s);
        begin
            v = $random(seed);
            nrst <= 1'h0;
            cable_length_result <= v[15:8];
            {interface_select_strap, negotiation_enable_strap, speed_strap, duplex_strap,
                isolate_strap, repeater_strap, link_down_power_save} <= s;
            repeat (8) @(posedge sys_clk);
            nrst <= 1'h1;
            repeat (4) @(posedge sys_clk);
            foreach (mdl[j])
                mdl[j] = 16'h0000;
            mdl[19] = 16'h0023;
            mdl[22] = {v[15:8], 8'h00};
            mdl[4] = {7'h00, s[4] & s[3], s[4], s[3], 6'h21};
        end
    endtask
    task rd(input [4:0] a);
        begin
            mac.xfer(2'h2, phy_addr_strap, a, 16'h0000, r);
            chk("reg", r, mdl[a]);
        end
    endtask
    task wr(input [4:0] a, input [15:0] d);
        begin
            mac.xfer(2'h1, phy_addr_strap, a, d, r);
            case (a)
                5'h13: mdl[a] = d & 16'h0023;
                5'h16: mdl[a] = {mdl[a][15:8], d[7:0]};
                5'h04, 5'h14, 5'h15, 5'h17, 5'h18: mdl[a] = d;
                default: ;
            endcase
        end
    endtask
    initial
        forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        if (p && !mii_rx_clk && rq.size() > 0)
            chk("rxd", mii_rxd, rq.pop_front());
        if (line_tx_valid && mii_tx_en)
        begin
            txn = txn + 1;
            chk("txd", line_tx_nibble, mii_txd);
        end
        p = mii_rx_clk;
    end
    initial
    begin
        #6000000;
        error_cnt = error_cnt + 1;
        give_verdict;
    end
    initial
    begin
        boot(7'h49);
        chk("mode", {speed_100, full_duplex, link_pulse_en}, 3'h2);
        for (i = 0; i < 7; i = i + 1)
            rd(rl[i]);
        for (i = 0; i < 7; i = i + 1)
        begin
            wr(rl[i], $random(seed));
            rd(rl[i]);
        end
        wr(5'h13, 16'h0002);
        chk("cfg", {link_disable_n, heartbeat_enable, jabber_enable, link_up}, 4'h5);
        mac.xfer(2'h2, phy_addr_strap ^ 5'h01, 5'h13, 16'h0000, r);
        chk("other_addr", r, 16'hffff);
        @(posedge sys_clk) rx10_preamble_ok <= 1'h1;
        @(posedge sys_clk) rx10_preamble_ok <= 1'h0;
        repeat (6) @(posedge sys_clk);
        chk("crs10", {mii_crs, mii_rx_dv}, 2'h3);
        @(negedge mii_rx_clk);
        for (i = 0; i < 13; i = i + 1)
        begin
            v = $random(seed);
            @(posedge sys_clk);
            if (rx10_nib_valid && rx_nib_ready)
            begin
                acc = acc + 1;
                rq.push_back(rx10_nib);
            end
            {rx10_nib_valid, rx10_nib} <= {i < 12, v[3:0]};
        end
        chk("refused", acc < 12, 1'h1);
        repeat (60) @(posedge sys_clk);
        chk("drained", rq.size(), 16'h0000);
        @(posedge sys_clk) rx10_idle_ok <= 1'h1;
        @(posedge sys_clk) rx10_idle_ok <= 1'h0;
        repeat (6) @(posedge sys_clk);
        chk("idle10", {mii_crs, mii_rx_dv}, 2'h0);
        v = $random(seed);
        @(posedge sys_clk) {mii_tx_en, mii_txd} <= {1'h1, v[3:0]};
        repeat (40) @(posedge sys_clk) mii_tx_er <= ~mii_tx_er;
        chk("crs_tx", mii_crs, 1'h1);
        @(posedge sys_clk) mii_tx_en <= 1'h0;
        chk("tx_count", txn > 5, 1'h1);
        boot(7'h7a);
        rd(5'h04);
        wr(5'h04, mdl[4] | 16'h0400);
        rd(5'h04);
        @(posedge sys_clk) {partner_valid, partner_ability} <= {1'h1, 16'h0421};
        @(posedge sys_clk) partner_valid <= 1'h0;
        mdl[5] = 16'h0421;
        rd(5'h05);
        chk("resolved", {speed_100, full_duplex, repeater_mode}, 3'h1);
        @(posedge sys_clk) an_idle100_seen <= 1'h1;
        @(posedge sys_clk) {an_idle100_seen, mii_tx_en} <= 2'h1;
        repeat (6) @(posedge sys_clk);
        chk("idle100", {speed_100, full_duplex, mii_crs}, 3'h4);
        @(posedge sys_clk) {rx_sym_valid, rx_sym, mii_tx_en} <= {1'h1, 5'h18, 1'h0};
        @(posedge sys_clk) rx_sym <= 5'h1f;
        @(posedge sys_clk) rx_sym_valid <= 1'h0;
        boot(7'h14);
        mac.xfer(2'h2, phy_addr_strap, 5'h13, 16'h0000, r);
        chk("isolated", r, 16'hffff);
        chk("serial", {sni_mode, speed_100, mii_oe_n}, 3'h5);
        give_verdict;
    end
endmodule
